// ===== core/hbd_map.vh
`ifndef HBD_MAP_VH
`define HBD_MAP_VH

// command word fields
`define HBD_CMD_SRR      15
`define HBD_CMD_GRP      14
`define HBD_CMD_UNDERLOAD_SHUTDOWN_ENABLE    13
`define HBD_CMD_EN_HI    12
`define HBD_CMD_EN_LO    7
`define HBD_CMD_CFG_HI   6
`define HBD_CMD_CFG_LO   1
`define HBD_CMD_OVERVOLTAGE_LOCKOUT_ENABLE     0

// status word fields
`define HBD_ST_OCS       15
`define HBD_ST_PSF       14
`define HBD_ST_ULD       13
`define HBD_ST_TW        0

// per-channel status codes
`define HBD_CH_OFF       2'h0
`define HBD_CH_OCS       2'h1
`define HBD_CH_ULD       2'h2
`define HBD_CH_ON        2'h3

// reset values
`define HBD_WORD_RST     16'h0000

// frame length check
`define HBD_FIRST_LEN    8'h10

// timing
`define HBD_CLK_NS       5
`define HBD_DEAD_NS      1000
`define HBD_DEAD_CYC     ((`HBD_DEAD_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_ULD_US       200
`define HBD_ULD_CYC      ((`HBD_ULD_US * 1000) / `HBD_CLK_NS)

`endif

// ===== core/hbd_fifo.v
`timescale 1ns/10ps
module hbd_fifo #(
    parameter W  = 16,
    parameter D  = 8,
    parameter AW = 3
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst_b,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire         do_push;
    wire         do_pop;

    // honest full and empty from the word count
    assign in_ready  = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    // storage array, no reset needed
    always @(posedge clock)
    begin
        if (do_push)
            mem[wr_ptr] <= in_data;
    end

    // pointers wrap at depth
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end
endmodule

// ===== core/hbd_core.v
`timescale 1ns/10ps
`include "hbd_map.vh"
module hbd_core #(
    parameter NCH      = 12,
    parameter DEAD_CYC = `HBD_DEAD_CYC,
    parameter ULD_CYC  = `HBD_ULD_CYC,
    parameter FDEPTH   = 8
) (
    // clock and reset
    input  wire            clock,
    input  wire            rst_b,
    // control pins
    input  wire            enable,
    input  wire            chip_select_n,
    input  wire            serial_clock,
    input  wire            serial_in,
    // supply monitors
    input  wire            driver_supply_undervoltage,
    input  wire            driver_supply_overvoltage,
    // per-channel detectors
    input  wire [NCH-1:0]  overcurrent_det,
    input  wire [NCH-1:0]  underload_det,
    input  wire [NCH-1:0]  thermal_shutdown_det,
    input  wire [NCH-1:0]  thermal_warning_det,
    // serial output pin
    output reg             serial_out,
    output reg             serial_out_en,
    // bridge drivers
    output reg  [NCH-1:0]  high_side_on,
    output reg  [NCH-1:0]  low_side_on,
    // link back-pressure
    output reg             command_stall
);
    localparam HALF = NCH / 2;
    localparam NA   = 6 + 4 * NCH;
    // two-stage synchroniser for all outside inputs
    reg  [NA-1:0] sync1;
    reg  [NA-1:0] sync2;
    wire [NA-1:0] async_in;
    assign async_in = {thermal_warning_det, thermal_shutdown_det,
                       underload_det, overcurrent_det,
                       driver_supply_overvoltage, driver_supply_undervoltage,
                       enable, serial_in, serial_clock, chip_select_n};

    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            sync1 <= {NA{1'b0}};
            sync2 <= {NA{1'b0}};
        end
        else
        begin
            sync1 <= async_in;
            sync2 <= sync1;
        end
    end
    wire           cs_n_s = sync2[0];
    wire           sclk_s = sync2[1];
    wire           si_s   = sync2[2];
    wire           en_s   = sync2[3];
    wire           uv_s   = sync2[4];
    wire           ov_s   = sync2[5];
    wire [NCH-1:0] oc_s   = sync2[6 +: NCH];
    wire [NCH-1:0] ul_s   = sync2[6+NCH +: NCH];
    wire [NCH-1:0] ts_s   = sync2[6+2*NCH +: NCH];
    wire [NCH-1:0] tw_s   = sync2[6+3*NCH +: NCH];
    // logic runs only out of reset with enable high
    wire run = rst_b & en_s;

    // six group bits spread onto the twelve channels
    function [NCH-1:0] grp_field;
        input            g;
        input [HALF-1:0] v;
        begin
            grp_field = g ? {v, {HALF{1'b0}}} : {{HALF{1'b0}}, v};
        end
    endfunction

    // per-channel status, overcurrent first
    function [1:0] chan_code;
        input oc;
        input ul;
        input on;
        begin
            if (oc)
                chan_code = `HBD_CH_OCS;
            else if (ul)
                chan_code = `HBD_CH_ULD;
            else if (on)
                chan_code = `HBD_CH_ON;
            else
                chan_code = `HBD_CH_OFF;
        end
    endfunction

    // edge detection on the sampled link pins
    reg cs_prev;
    reg sclk_prev;
    wire cs_fall   = cs_prev & ~cs_n_s;
    wire cs_rise   = ~cs_prev & cs_n_s;
    wire sclk_rise = ~sclk_prev & sclk_s & ~cs_n_s;
    always @(posedge clock)
    begin
        if (!run)
        begin
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b0;
        end
        else
        begin
            cs_prev   <= cs_n_s;
            sclk_prev <= sclk_s;
        end
    end
    // fault and command state
    reg [NCH-1:0]  ocs_lat;
    reg [NCH-1:0]  uld_lat;
    reg [NCH-1:0]  tsd_lat;
    reg [NCH-1:0]  en_reg;
    reg [NCH-1:0]  cfg_reg;
    reg [1:0]      underload_shutdown_enable_reg;
    reg            overvoltage_lockout_enable_reg;
    reg            cur_group;
    // link shift path, also the receive register
    reg [15:0] shift;
    reg        so_bit;
    reg        first_done;
    reg [7:0]  bit_count;
    reg        len_ge16;
    reg [15:0] next_status;
    // status word of the selected group, frozen at frame start
    integer k;
    always @*
    begin
        next_status = `HBD_WORD_RST;
        next_status[`HBD_ST_OCS] = |(ocs_lat & grp_field(cur_group,
                                        {HALF{1'b1}}));
        next_status[`HBD_ST_PSF] = uv_s | ov_s;
        next_status[`HBD_ST_ULD] = |(uld_lat & grp_field(cur_group,
                                        {HALF{1'b1}}));
        next_status[`HBD_ST_TW]  = |tw_s;
        for (k = 0; k < HALF; k = k + 1)
            next_status[2*k+1 +: 2] =
                chan_code(ocs_lat[cur_group*HALF+k],
                          uld_lat[cur_group*HALF+k],
                          high_side_on[cur_group*HALF+k] |
                          low_side_on[cur_group*HALF+k]);
    end

    // shift register: load status at select fall, shift on rising clock
    always @(posedge clock)
    begin
        if (!run)
        begin
            shift      <= `HBD_WORD_RST;
            so_bit     <= 1'b0;
            first_done <= 1'b0;
            bit_count  <= 8'h00;
            len_ge16   <= 1'b0;
        end
        else if (cs_fall)
        begin
            shift      <= next_status;
            first_done <= 1'b0;
            bit_count  <= 8'h00;
            len_ge16   <= 1'b0;
        end
        else if (sclk_rise)
        begin
            so_bit     <= shift[15];
            shift      <= {shift[14:0], si_s};
            first_done <= 1'b1;
            bit_count  <= bit_count + 8'h01;
            if (bit_count + 8'h01 >= `HBD_FIRST_LEN)
                len_ge16 <= 1'b1;
        end
    end
    // frame length: at least sixteen and a multiple of eight
    wire frame_ok = len_ge16 & (bit_count[2:0] == 3'h0);
    wire tsd_any  = |tsd_lat;

    // serial output pin, hi-z whenever not selected or not running
    always @(posedge clock)
    begin
        if (!run)
        begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end
        else
        begin
            serial_out_en <= ~cs_n_s;
            if (!first_done)
                serial_out <= tsd_any | si_s;
            else
                serial_out <= so_bit;
        end
    end

    // accepted words wait in the fifo until the drivers are idle
    reg         push_valid;
    reg  [15:0] push_word;
    wire        push_ready;
    wire        pop_valid;
    wire [15:0] pop_word;
    reg         apply_ready;
    always @(posedge clock)
    begin
        if (!run)
        begin
            push_valid    <= 1'b0;
            push_word     <= `HBD_WORD_RST;
            command_stall <= 1'b0;
        end
        else
        begin
            if (cs_rise && frame_ok && !push_valid)
            begin
                push_valid <= 1'b1;
                push_word  <= shift;
            end
            else if (push_valid && push_ready)
                push_valid <= 1'b0;
            command_stall <= push_valid & ~push_ready;
        end
    end
    hbd_fifo #(
        .W  (16),
        .D  (FDEPTH),
        .AW (3)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (run),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (pop_valid),
        .out_ready (apply_ready),
        .out_data  (pop_word)
    );
    // decoded command fields
    wire           do_apply = pop_valid & apply_ready;
    wire           w_grp    = pop_word[`HBD_CMD_GRP];
    wire [NCH-1:0] w_mask   = grp_field(w_grp, {HALF{1'b1}});
    wire [NCH-1:0] w_en     = grp_field(w_grp,
                                pop_word[`HBD_CMD_EN_HI:`HBD_CMD_EN_LO]);
    wire [NCH-1:0] w_cfg    = grp_field(w_grp,
                                pop_word[`HBD_CMD_CFG_HI:`HBD_CMD_CFG_LO]);
    wire [NCH-1:0] clr_mask = (do_apply && pop_word[`HBD_CMD_SRR])
                              ? w_mask : {NCH{1'b0}};

    // command registers, written even during supply lockout
    always @(posedge clock)
    begin
        if (!run)
        begin
            en_reg    <= {NCH{1'b0}};
            cfg_reg   <= {NCH{1'b0}};
            underload_shutdown_enable_reg <= 2'h0;
            overvoltage_lockout_enable_reg  <= 1'b0;
            cur_group <= 1'b0;
        end
        else if (do_apply)
        begin
            en_reg    <= (en_reg & ~w_mask) | w_en;
            cfg_reg   <= (cfg_reg & ~w_mask) | w_cfg;
            underload_shutdown_enable_reg[w_grp] <= pop_word[`HBD_CMD_UNDERLOAD_SHUTDOWN_ENABLE];
            overvoltage_lockout_enable_reg  <= pop_word[`HBD_CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
            cur_group <= w_grp;
        end
    end

    // global underload delay timer
    reg  [19:0]    uld_timer;
    wire [NCH-1:0] drv_on  = high_side_on | low_side_on;
    wire [NCH-1:0] ul_act  = ul_s & drv_on;
    wire           uld_due = (uld_timer == ULD_CYC[19:0]);
    always @(posedge clock)
    begin
        if (!run || !(|ul_act))
            uld_timer <= 20'h00000;
        else if (!uld_due)
            uld_timer <= uld_timer + 20'h00001;
    end
    // latched faults: a new event wins over a status reset
    wire [NCH-1:0] uld_set = uld_due ? ul_act : {NCH{1'b0}};
    always @(posedge clock)
    begin
        if (!run)
        begin
            ocs_lat <= {NCH{1'b0}};
            uld_lat <= {NCH{1'b0}};
            tsd_lat <= {NCH{1'b0}};
        end
        else
        begin
            ocs_lat <= (ocs_lat & ~clr_mask) | (oc_s & drv_on);
            tsd_lat <= (tsd_lat & ~clr_mask) | ts_s;
            uld_lat <= (uld_lat & ~clr_mask) | uld_set;
        end
    end

    // shutdown terms: latched faults plus supply lockout
    wire           lockout = uv_s | (ov_s & overvoltage_lockout_enable_reg);
    wire [NCH-1:0] uld_sd  = uld_lat & {{HALF{underload_shutdown_enable_reg[1]}},
                                        {HALF{underload_shutdown_enable_reg[0]}}};
    wire [NCH-1:0] shut    = ocs_lat | tsd_lat | uld_sd
                             | {NCH{lockout}};
    wire [NCH-1:0] want_hs = en_reg & cfg_reg & ~shut;
    wire [NCH-1:0] want_ls = en_reg & ~cfg_reg & ~shut;
    // per-channel dead-time counters
    reg [7:0] dead [0:NCH-1];
    integer i;
    integer j;

    // drain stalls while any channel sits in dead time
    always @*
    begin
        apply_ready = 1'b1;
        for (j = 0; j < NCH; j = j + 1)
            if (dead[j] != 8'h00)
                apply_ready = 1'b0;
    end

    // driver switching with non-overlap
    always @(posedge clock)
    begin
        if (!run)
        begin
            high_side_on <= {NCH{1'b0}};
            low_side_on  <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1)
                dead[i] <= 8'h00;
        end
        else
        begin
            for (i = 0; i < NCH; i = i + 1)
            begin
                if (shut[i])
                begin
                    high_side_on[i] <= 1'b0;
                    low_side_on[i]  <= 1'b0;
                    dead[i]         <= 8'h00;
                end
                else if (dead[i] != 8'h00)
                    dead[i] <= dead[i] - 8'h01;
                else if (high_side_on[i] && !want_hs[i])
                begin
                    high_side_on[i] <= 1'b0;
                    if (want_ls[i])
                        dead[i] <= DEAD_CYC[7:0];
                end
                else if (low_side_on[i] && !want_ls[i])
                begin
                    low_side_on[i] <= 1'b0;
                    if (want_hs[i])
                        dead[i] <= DEAD_CYC[7:0];
                end
                else
                begin
                    high_side_on[i] <= want_hs[i] & ~low_side_on[i];
                    low_side_on[i]  <= want_ls[i] & ~high_side_on[i];
                end
            end
        end
    end
endmodule

// ===== sim/hbd_core_monitor.sv
`timescale 1ns/10ps
module hbd_core_monitor #(
    parameter NCH = 12
) (
    // clock and reset
    input wire           clock,
    input wire           rst_b,
    // pins in
    input wire           enable,
    input wire           chip_select_n,
    input wire           serial_clock,
    input wire           serial_in,
    input wire           driver_supply_undervoltage,
    input wire [NCH-1:0] overcurrent_det,
    input wire [NCH-1:0] thermal_shutdown_det,
    // pins out
    input wire           serial_out,
    input wire           serial_out_en,
    input wire [NCH-1:0] high_side_on,
    input wire [NCH-1:0] low_side_on
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire [NCH-1:0] det = thermal_shutdown_det | overcurrent_det;
    reg  [NCH-1:0] f1, f2, f3, f4, f5;
    reg            armed;
    // faults held six samples; armed until the first link clock rise
    always @(posedge clock)
    begin
        f1 <= det;
        f2 <= f1 & det;
        f3 <= f2 & det;
        f4 <= f3 & det;
        f5 <= f4 & det;
        armed <= chip_select_n | (armed & ~serial_clock);
    end
    a_sides_exclusive: assert property (
        (high_side_on & low_side_on) == 0) else $error("both sides on");
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_b |=> high_side_on == 0 && low_side_on == 0 && !serial_out_en)
        else $error("outputs not cleared by reset");
    a_enable_off: assert property (
        !enable [*5] |-> high_side_on == 0 && low_side_on == 0
        && !serial_out_en) else $error("outputs on while disabled");
    a_supply_lockout: assert property (
        driver_supply_undervoltage [*6] |-> high_side_on == 0
        && low_side_on == 0) else $error("outputs on in lockout");
    a_so_drive: assert property (
        $fell(chip_select_n) && enable |-> ##4 serial_out_en)
        else $error("serial output not driven in frame");
    a_so_idle: assert property (
        chip_select_n [*6] |-> !serial_out_en)
        else $error("serial output driven outside frame");
    a_so_holds: assert property (
        $rose(serial_clock) |-> $stable(serial_out) [*3])
        else $error("serial output changed too early");
    a_flag_or_input: assert property (
        (armed && serial_in && !chip_select_n) [*5] |-> serial_out)
        else $error("input not passed before first clock");
    a_fault_off: assert property (
        (f5 & det & (high_side_on | low_side_on)) == 0)
        else $error("faulted channel still driven");
    a_dead_gap: assert property (
        $fell(high_side_on[0]) |-> !low_side_on[0] [*4])
        else $error("no dead time on side swap");
endmodule
bind hbd_core hbd_core_monitor #(.NCH(NCH)) mon (
    .clock(clock), .rst_b(rst_b), .enable(enable),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_in(serial_in),
    .driver_supply_undervoltage(driver_supply_undervoltage),
    .overcurrent_det(overcurrent_det),
    .thermal_shutdown_det(thermal_shutdown_det),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .high_side_on(high_side_on), .low_side_on(low_side_on));

// ===== sim/hbd_host.sv
`timescale 1ns/10ps
module hbd_host (
    // clock
    input  wire clock,
    // link pins
    input  wire serial_out,
    input  wire serial_out_en,
    output reg  chip_select_n,
    output reg  serial_clock,
    output reg  serial_in
);
    // a released pin reads the inverse level, never a stale copy
    wire so_pin = serial_out_en ? serial_out : ~serial_out;
    // idle levels before any frame
    initial
    begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    // wait cycles, then change pins just after the edge
    task tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    // one frame msb first; far device word goes first
    task xfer(input int n, input logic [31:0] tx, input logic up,
              output logic pre, output logic [31:0] rx);
        int i;
        rx = 32'h0;
        chip_select_n = 1'b0;
        tick(2);
        serial_in = up; // upstream flag arriving on the input
        tick(8);
        pre = so_pin; // flag read apart from each status word
        for (i = n - 1; i >= 0; i--)
        begin
            serial_in = tx[i];
            tick(16);
            serial_clock = 1'b1;
            tick(16);
            rx = {rx[30:0], so_pin};
            serial_clock = 1'b0;
        end
        serial_in = 1'b0;
        tick(16);
        chip_select_n = 1'b1;
        tick(16);
    endtask
endmodule

// ===== sim/test_hbd_core.sv
`timescale 1ns/10ps
module test_hbd_core;
    // stimulus and observed pins
    logic        clock;
    logic        rst_b;
    logic        enable;
    logic        uv;
    logic        ov;
    logic [11:0] tsd;
    logic [11:0] tw;
    logic [11:0] ul;
    logic [11:0] oc;
    wire         cs_n;
    wire         sck;
    wire         si;
    wire         so;
    wire         so_en;
    wire         stall;
    wire  [11:0] hs;
    wire  [11:0] ls;
    logic        pre;
    logic [31:0] rx;
    int          error_cnt;
    int          comparisons;
    int          cycles;
    // short dead time and underload delay keep the run brief
    hbd_core #(.DEAD_CYC(4), .ULD_CYC(20)) uut (
        .clock(clock), .rst_b(rst_b), .enable(enable),
        .chip_select_n(cs_n), .serial_clock(sck), .serial_in(si),
        .driver_supply_undervoltage(uv), .driver_supply_overvoltage(ov),
        .overcurrent_det(oc), .underload_det(ul),
        .thermal_shutdown_det(tsd), .thermal_warning_det(tw),
        .serial_out(so), .serial_out_en(so_en), .high_side_on(hs),
        .low_side_on(ls), .command_stall(stall));
    hbd_host host (.clock(clock), .serial_out(so), .serial_out_en(so_en),
        .chip_select_n(cs_n), .serial_clock(sck), .serial_in(si));
    // 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // let the last command settle, then compare both driver sides
    task outs(input logic [11:0] eh, input logic [11:0] el);
        host.tick(8);
        check(hs, eh);
        check(ls, el);
    endtask
    task end_of_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // idle after reset, first status word empty
    task run_reset_state;
        check(so_en, 1'b0);
        outs(12'h000, 12'h000);
        host.xfer(16, 32'h0, 1'b0, pre, rx);
        check({pre, rx[15:0]}, 17'h0);
    endtask
    // group and side select, status of driven channels, side swap
    task run_drive;
        host.xfer(16, 32'h1F83, 1'b0, pre, rx);
        outs(12'h001, 12'h03E);
        host.xfer(16, 32'h5F83, 1'b0, pre, rx);
        check(rx[15:0], 16'h1FFE);
        outs(12'h041, 12'hFBE);
        host.xfer(16, 32'h1F81, 1'b0, pre, rx);
        outs(12'h040, 12'hFBF);
    endtask
    // short frame dropped, 24-bit frame takes its last word, byte passes on
    task run_frames;
        host.xfer(12, 32'h0, 1'b0, pre, rx);
        outs(12'h040, 12'hFBF);
        host.xfer(24, 32'h1F8000, 1'b0, pre, rx);
        outs(12'h040, 12'hF80);
        check(stall, 1'b0);
        check(rx[7:0], 8'h1F);
        check(rx[23:8], 16'h1FFE);
    endtask
    // lockout taking new settings, overvoltage with lockout off
    task run_supply;
        uv = 1'b1;
        outs(12'h000, 12'h000);
        host.xfer(16, 32'h5F81, 1'b0, pre, rx);
        check(rx[14], 1'b1);
        uv = 1'b0;
        host.tick(16);
        outs(12'h000, 12'hFC0);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check(rx[14], 1'b0);
        ov = 1'b1;
        outs(12'h000, 12'hFC0);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check(rx[14], 1'b1);
        ov = 1'b0;
        host.xfer(16, 32'h5F81, 1'b0, pre, rx);
        ov = 1'b1;
        outs(12'h000, 12'h000);
        ov = 1'b0;
        outs(12'h000, 12'hFC0);
    endtask
    // latched overcurrent on a driven channel, cleared by group reset
    task run_overcurrent;
        oc = 12'h100;
        host.tick(8);
        oc = 12'h000;
        outs(12'h000, 12'hEC0);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check({rx[15], rx[6:5]}, 3'b101);
        host.xfer(16, 32'hDF80, 1'b0, pre, rx);
        outs(12'h000, 12'hFC0);
    endtask
    // warning, latched shutdown, group reset, underload shutdown
    task run_faults;
        tw = 12'h040;
        host.tick(8);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check(rx[15:0], 16'h1FFF);
        outs(12'h000, 12'hFC0);
        tw = 12'h000;
        tsd = 12'h040;
        host.tick(8);
        tsd = 12'h000;
        outs(12'h000, 12'hF80);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check({pre, rx[0]}, 2'b10);
        outs(12'h000, 12'hF80);
        host.xfer(16, 32'hDF80, 1'b0, pre, rx);
        outs(12'h000, 12'hFC0);
        host.xfer(16, 32'h5F80, 1'b0, pre, rx);
        check(pre, 1'b0);
        host.xfer(16, 32'h7F80, 1'b1, pre, rx);
        check(pre, 1'b1);
        ul = 12'h080;
        host.tick(40);
        outs(12'h000, 12'hF40);
        host.xfer(16, 32'h7F80, 1'b0, pre, rx);
        check({rx[13], rx[4:3]}, 3'b110);
        ul = 12'h000;
        host.xfer(16, 32'hDF80, 1'b0, pre, rx);
        outs(12'h000, 12'hFC0);
    endtask
    // enable low clears drivers, command and status
    task run_enable;
        enable = 1'b0;
        outs(12'h000, 12'h000);
        enable = 1'b1;
        host.tick(8);
        host.xfer(16, 32'h0, 1'b0, pre, rx);
        check(rx[15:0], 16'h0000);
    endtask
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        enable = 1'b1;
        uv = 1'b0;
        ov = 1'b0;
        tsd = 12'h000;
        tw = 12'h000;
        ul = 12'h000;
        oc = 12'h000;
        host.tick(16);
        rst_b = 1'b1;
        host.tick(8);
        run_reset_state;
        run_drive;
        run_frames;
        run_supply;
        run_faults;
        run_overcurrent;
        run_enable;
        end_of_test;
    end
endmodule
